/* design/vsd_pkg.sv */
// package: constants for the slave address decode and chain block
package vsd_pkg;
    localparam logic [5:0] AM_A24_LO = 6'h38;
    localparam logic [5:0] AM_A24_HI = 6'h3F;
    localparam logic [5:0] AM_A32_LO = 6'h08;
    localparam logic [5:0] AM_A32_HI = 6'h0F;
    localparam logic [5:0] AM_A32_BLT = 6'h0B;
    localparam logic [5:0] AM_A32_MBLT = 6'h08;
    localparam logic [1:0] AM_BLT_SEL = 2'h3;
    localparam logic [1:0] AM_MBLT_SEL = 2'h0;
    localparam int MCST_HI = 31;
    localparam int MCST_LO = 24;
    localparam logic [15:0] OFS_GROUP = 16'h1010;
    localparam logic [15:0] OFS_CHAIN = 16'h1012;
    localparam logic [15:0] OFS_SLOT = 16'h1000;
    localparam logic [15:0] OFS_BUFFER = 16'h0000;
    localparam logic [15:0] OFS_BUFFER_END = 16'h0FFF;
    localparam logic [7:0] GROUP_RST = 8'hAA;
    localparam int CHAIN_FIRST_BIT = 1;
    localparam int CHAIN_LAST_BIT = 0;
    localparam logic [4:0] SLOT_RST = 5'h00;
    localparam int SLOT_MSB = 31;
    localparam int SLOT_LSB = 27;
    localparam logic [11:0] MATCH_WIDTH_RST = 12'h014;
    localparam logic [15:0] MATCH_OFFSET_RST = 16'hFFD8;
    localparam logic [11:0] EXTRA_SEARCH_RST = 12'h008;
    localparam logic [11:0] REJECT_MARGIN_RST = 12'h004;
    localparam logic [8:0] FIFO_SIZE_RST = 9'h100;
    localparam logic [3:0] HIT_LIMIT_RST = 4'h0;
    localparam int DEAD_TIME_NS = 5;
    localparam logic [1:0] DEAD_TIME_CODE = 2'h0;
    localparam logic [1:0] EDGE_LEADING = 2'h2;
    localparam int CLK_NS = 40;
    localparam int CONFIG_MS = 1000;
    localparam int CONFIG_CYCLES = CONFIG_MS * 25000;
endpackage

/* design/vsd_slave_decode.sv */
// vme slave decode with multicast, chained read token and power-up state
`timescale 1ns/1ps
module vsd_slave_decode #(
    parameter int CONFIG_CYCLES = vsd_pkg::CONFIG_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] rotary_a32_hi,
    input wire logic [7:0] rotary_a32_mid,
    input wire logic [7:0] rotary_a24_hi,
    input wire logic [7:0] rotary_a24_lo,
    input wire logic [31:0] vme_addr,
    input wire logic [5:0] vme_am,
    input wire logic vme_as,
    input wire logic vme_write,
    input wire logic [15:0] vme_wdata,
    input wire logic chain_in,
    input wire logic [31:0] buffer_word,
    input wire logic buffer_word_is_tag,
    input wire logic buffer_valid,
    input wire logic buffer_done,
    output logic chain_out,
    output logic [31:0] vme_rdata,
    output logic vme_rdata_oe,
    output logic vme_ack,
    output logic reg_wr,
    output logic [15:0] reg_offset,
    output logic [15:0] reg_wdata,
    output logic buffer_rd,
    output logic buffer_clear,
    output logic cfg_busy,
    output logic full_indicator,
    output logic error_indicator,
    output logic data_present_indicator,
    output logic core_match_en,
    output logic [11:0] core_match_width,
    output logic [15:0] core_match_offset,
    output logic [11:0] core_extra_search,
    output logic [11:0] core_reject_margin,
    output logic [8:0] core_fifo_size,
    output logic [3:0] core_hit_limit,
    output logic [1:0] core_dead_time,
    output logic [1:0] core_edge_mode,
    output logic core_channels_on,
    output logic [7:0] group_addr,
    output logic chain_first,
    output logic chain_last,
    output logic [4:0] slot_number_tag
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_XFER = 3'b100
    } vsd_state_e;

    typedef struct packed {
        vsd_state_e state;
        logic [2:0] as_sync;
        logic [2:0] tok_sync;
        logic [24:0] cfg_cnt;
        logic busy;
        logic [7:0] group;
        logic first;
        logic last;
        logic [4:0] slot;
        logic chain_rd;
        logic pass;
        logic ack;
        logic [31:0] rdata;
        logic oe;
        logic wr;
        logic [15:0] ofs;
        logic [15:0] wdata;
        logic rd;
        logic mcst;
    } vsd_s;

    vsd_s cur;
    vsd_s next_cur;

    logic as_now;
    logic tok_now;
    logic am_a24;
    logic am_a32;
    logic hit_a24;
    logic hit_a32;
    logic hit_group;
    logic chain_active;
    logic is_blt;
    logic in_buffer;

    assign as_now = cur.as_sync[2] & cur.as_sync[1];
    assign tok_now = cur.tok_sync[2] & cur.tok_sync[1];
    assign am_a24 = vme_am >= vsd_pkg::AM_A24_LO &&
        vme_am <= vsd_pkg::AM_A24_HI;
    assign am_a32 = vme_am >= vsd_pkg::AM_A32_LO &&
        vme_am <= vsd_pkg::AM_A32_HI;
    // base compare on upper bits only, 64 KB granule
    assign hit_a24 = am_a24 &&
        vme_addr[23:16] == rotary_a24_lo;
    assign hit_a32 = am_a32 && vme_addr[31:16] ==
        {rotary_a32_hi, rotary_a32_mid};
    assign hit_group = am_a32 &&
        vme_addr[vsd_pkg::MCST_HI:vsd_pkg::MCST_LO] == cur.group &&
        vme_addr[23:16] == 8'h00;
    assign chain_active = cur.first | cur.last;
    assign is_blt = vme_am[1:0] == vsd_pkg::AM_BLT_SEL ||
        vme_am[1:0] == vsd_pkg::AM_MBLT_SEL;
    assign in_buffer = vme_addr[15:0] <= vsd_pkg::OFS_BUFFER_END;

    always_comb begin
        next_cur = cur;
        next_cur.as_sync = {cur.as_sync[1:0], vme_as};
        next_cur.tok_sync = {cur.tok_sync[1:0], chain_in};
        next_cur.wr = 1'b0;
        next_cur.rd = 1'b0;
        if (cur.busy) begin
            // hold lamps on while the core configures
            if (cur.cfg_cnt == 25'(CONFIG_CYCLES - 1)) begin
                next_cur.busy = 1'b0;
            end else begin
                next_cur.cfg_cnt = cur.cfg_cnt + 25'h0000001;
            end
        end
        unique case (cur.state)
            ST_IDLE: begin
                next_cur.ack = 1'b0;
                next_cur.oe = 1'b0;
                next_cur.chain_rd = 1'b0;
                if (as_now && !cur.busy) begin
                    if (hit_a32 || (hit_a24 && !hit_group)) begin
                        next_cur.state = ST_XFER;
                        next_cur.mcst = 1'b0;
                        next_cur.ofs = vme_addr[15:0];
                        next_cur.wdata = vme_wdata;
                        next_cur.wr = vme_write;
                        next_cur.rd = !vme_write;
                    end else if (hit_group && chain_active &&
                        (vme_write || (is_blt && in_buffer))) begin
                        // every board with a chain flag set takes part; all but the first-only board wait here for the token
                        next_cur.chain_rd = !vme_write;
                        next_cur.mcst = 1'b1;
                        next_cur.ofs = vme_addr[15:0];
                        next_cur.wdata = vme_wdata;
                        next_cur.state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (!as_now) begin
                    next_cur.state = ST_IDLE;
                    next_cur.pass = 1'b0;
                end else if ((cur.first && !cur.last) || tok_now) begin
                    next_cur.state = ST_XFER;
                    next_cur.wr = !cur.chain_rd;
                    next_cur.rd = cur.chain_rd;
                end
            end
            ST_XFER: begin
                next_cur.ack = 1'b1;
                next_cur.oe = !vme_write;
                if (cur.chain_rd) begin
                    next_cur.rdata = buffer_word;
                    if (buffer_word_is_tag) begin
                        next_cur.rdata[vsd_pkg::SLOT_MSB:vsd_pkg::SLOT_LSB] =
                            cur.slot;
                    end
                    if (buffer_done || !buffer_valid) begin
                        next_cur.pass = 1'b1;
                    end
                end else begin
                    next_cur.rdata = buffer_word;
                    // multicast write stored here, hand token on
                    if (cur.mcst) begin
                        next_cur.pass = 1'b1;
                    end
                end
                if (!as_now) begin
                    next_cur.state = ST_IDLE;
                    next_cur.ack = 1'b0;
                    next_cur.oe = 1'b0;
                    if (!cur.chain_rd) begin
                        next_cur.pass = 1'b0;
                    end
                end
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
        if (cur.wr) begin
            unique case (cur.ofs)
                vsd_pkg::OFS_GROUP: next_cur.group = cur.wdata[7:0];
                vsd_pkg::OFS_CHAIN: begin
                    next_cur.first = cur.wdata[vsd_pkg::CHAIN_FIRST_BIT];
                    next_cur.last = cur.wdata[vsd_pkg::CHAIN_LAST_BIT];
                end
                vsd_pkg::OFS_SLOT: next_cur.slot = cur.wdata[4:0];
                default: begin
                end
            endcase
        end
        // token released once the master drops strobe after a write; after a chained read only once chain_rd has cleared in idle
        if (!as_now && !cur.chain_rd) begin
            next_cur.pass = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur <= '0;
            cur.state <= ST_IDLE;
            cur.busy <= 1'b1;
            cur.group <= vsd_pkg::GROUP_RST;
            cur.first <= 1'b0;
            cur.last <= 1'b0;
            cur.slot <= vsd_pkg::SLOT_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // single-board cycles never forward the token; last board keeps it
    assign chain_out = cur.pass && !(cur.last && !cur.first);
    assign vme_ack = cur.ack;
    assign vme_rdata = cur.rdata;
    assign vme_rdata_oe = cur.oe;
    assign reg_wr = cur.wr;
    assign reg_offset = cur.ofs;
    assign reg_wdata = cur.wdata;
    assign buffer_rd = cur.rd && cur.ofs <= vsd_pkg::OFS_BUFFER_END;
    assign buffer_clear = cur.busy;
    assign cfg_busy = cur.busy;
    assign full_indicator = cur.busy;
    assign error_indicator = cur.busy;
    assign data_present_indicator = cur.busy;
    assign core_match_en = 1'b0;
    assign core_match_width = vsd_pkg::MATCH_WIDTH_RST;
    assign core_match_offset = vsd_pkg::MATCH_OFFSET_RST;
    assign core_extra_search = vsd_pkg::EXTRA_SEARCH_RST;
    assign core_reject_margin = vsd_pkg::REJECT_MARGIN_RST;
    assign core_fifo_size = vsd_pkg::FIFO_SIZE_RST;
    assign core_hit_limit = vsd_pkg::HIT_LIMIT_RST;
    assign core_dead_time = vsd_pkg::DEAD_TIME_CODE;
    assign core_edge_mode = vsd_pkg::EDGE_LEADING;
    assign core_channels_on = 1'b1;
    assign group_addr = cur.group;
    assign chain_first = cur.first;
    assign chain_last = cur.last;
    assign slot_number_tag = cur.slot;

    a_lamps_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
        cur.busy |-> full_indicator && error_indicator &&
        data_present_indicator) else $error("lamps off while busy");
    a_no_ack_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        cur.state == ST_IDLE |=> !vme_ack && !vme_rdata_oe)
        else $error("ack without decode");
    a_token_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        cur.state == ST_WAIT && !(cur.first && !cur.last) && !tok_now |=>
        cur.state != ST_XFER) else $error("data moved without token");
    a_wait_no_ack: assert property (@(posedge core_clk) disable iff (sys_rst)
        cur.state == ST_WAIT |-> !vme_ack && !vme_rdata_oe)
        else $error("ack without token");
    a_group_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        cur.wr && cur.ofs == vsd_pkg::OFS_GROUP |=>
        group_addr == $past(cur.wdata[7:0]))
        else $error("group byte not stored");
    a_chain_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        cur.wr && cur.ofs == vsd_pkg::OFS_CHAIN |=>
        chain_first == $past(cur.wdata[1]) &&
        chain_last == $past(cur.wdata[0]))
        else $error("chain flags not stored");
    a_bad_am: assert property (@(posedge core_clk) disable iff (sys_rst)
        cur.state == ST_IDLE && as_now && !am_a24 && !am_a32 |=>
        cur.state == ST_IDLE) else $error("odd modifier accepted");
    a_last_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        chain_last && !chain_first |-> !chain_out)
        else $error("last board passed");
    a_tag_slot: assert property (@(posedge core_clk) disable iff (sys_rst)
        cur.state == ST_XFER && cur.chain_rd && buffer_word_is_tag |=>
        vme_rdata[31:27] == $past(cur.slot))
        else $error("slot tag missing");
    a_busy_ends: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(cur.busy) |-> !full_indicator)
        else $error("lamps stuck");
    c_single: cover property (@(posedge core_clk) disable iff (sys_rst)
        cur.state == ST_IDLE ##1 cur.state == ST_XFER && !cur.chain_rd);
    c_chain_rd: cover property (@(posedge core_clk) disable iff (sys_rst)
        cur.state == ST_WAIT ##1 cur.state == ST_XFER && cur.chain_rd);
    c_pass: cover property (@(posedge core_clk) disable iff (sys_rst)
        $rose(chain_out));
endmodule

/* testbench/vsd_master_model.sv */
// vme master model: strobe, address, modifier and write data
`timescale 1ns/1ps
module vsd_master_model (
    input wire logic core_clk,
    input wire logic vme_ack,
    input wire logic [31:0] vme_rdata,
    output logic [31:0] vme_addr,
    output logic [5:0] vme_am,
    output logic vme_as,
    output logic vme_write,
    output logic [15:0] vme_wdata
);
    initial begin
        vme_addr = 32'h00000000;
        vme_am = 6'h00;
        vme_as = 1'b0;
        vme_write = 1'b0;
        vme_wdata = 16'h0000;
    end
    // hold the request until ack or give up; then release and rest
    task automatic cycle(input logic [31:0] a, input logic [5:0] m,
            input logic w, input logic [15:0] d,
            output logic acked, output logic [31:0] rd);
        int n;
        n = 0;
        acked = 1'b0;
        rd = 32'h00000000;
        @(posedge core_clk);
        vme_addr <= a;
        vme_am <= m;
        vme_write <= w;
        vme_wdata <= d;
        vme_as <= 1'b1;
        while (n < 12 && !acked) begin
            @(posedge core_clk);
            n++;
            if (vme_ack === 1'b1) begin
                acked = 1'b1;
                rd = vme_rdata;
            end
        end
        vme_as <= 1'b0;
        // released lines must not keep a stale value
        vme_addr <= ~a;
        vme_wdata <= ~d;
        repeat (7) @(posedge core_clk);
    endtask
endmodule

/* testbench/vsd_slave_decode_tb_top.sv */
// testbench: random and corner cases for the slave decode block
`timescale 1ns/1ps
module vsd_slave_decode_tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] rotary_a32_hi, rotary_a32_mid, rotary_a24_hi, rotary_a24_lo;
    logic [31:0] vme_addr, vme_rdata;
    logic [31:0] buffer_word = 32'h00000000;
    logic [5:0] vme_am;
    logic [15:0] vme_wdata;
    logic vme_as, vme_write, vme_ack, chain_out, core_match_en;
    logic chain_in = 1'b0, buffer_word_is_tag = 1'b0;
    logic buffer_valid = 1'b0, buffer_done = 1'b0;
    logic buffer_clear, cfg_busy, full_indicator, error_indicator;
    logic data_present_indicator, core_channels_on, chain_first, chain_last;
    logic [11:0] core_match_width, core_extra_search, core_reject_margin;
    logic [15:0] core_match_offset;
    logic [8:0] core_fifo_size;
    logic [3:0] core_hit_limit;
    logic [1:0] core_dead_time, core_edge_mode;
    logic [7:0] group_addr, g;
    logic [4:0] slot_number_tag, s;
    logic [31:0] seed = 32'h00004D00;
    logic [31:0] r, rd_s, a;
    logic ack_s;
    int mismatches = 0, samples_checked = 0, cyc = 0;
    int tok_cnt = 0, tok_base = 0;

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (chain_out === 1'b1) tok_cnt <= tok_cnt + 1;

    vsd_slave_decode #(.CONFIG_CYCLES(16)) u_dut (.core_clk, .sys_rst,
        .rotary_a32_hi, .rotary_a32_mid, .rotary_a24_hi, .rotary_a24_lo,
        .vme_addr, .vme_am, .vme_as, .vme_write, .vme_wdata, .chain_in,
        .buffer_word, .buffer_word_is_tag, .buffer_valid, .buffer_done,
        .chain_out, .vme_rdata, .vme_rdata_oe(), .vme_ack, .reg_wr(),
        .reg_offset(), .reg_wdata(), .buffer_rd(), .buffer_clear,
        .cfg_busy, .full_indicator, .error_indicator,
        .data_present_indicator, .core_match_en, .core_match_width,
        .core_match_offset, .core_extra_search, .core_reject_margin,
        .core_fifo_size, .core_hit_limit, .core_dead_time, .core_edge_mode,
        .core_channels_on, .group_addr, .chain_first, .chain_last,
        .slot_number_tag);
    vsd_master_model u_master (.core_clk, .vme_ack, .vme_rdata, .vme_addr,
        .vme_am, .vme_as, .vme_write, .vme_wdata);

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic am_ok(input logic [5:0] m);
        return (m >= vsd_pkg::AM_A24_LO && m <= vsd_pkg::AM_A24_HI) ||
            (m >= vsd_pkg::AM_A32_LO && m <= vsd_pkg::AM_A32_HI);
    endfunction
    task automatic chk(input string nm, input logic [63:0] e,
            input logic [63:0] v);
        samples_checked++;
        if (v !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic acc(input logic [31:0] ad, input logic [5:0] m,
            input logic w, input logic [15:0] d, input logic e);
        u_master.cycle(ad, m, w, d, ack_s, rd_s);
        chk("vme_ack", {63'h0, e}, {63'h0, ack_s});
    endtask
    task automatic reset_state();
        // let the reset settle before looking at the state
        repeat (2) @(posedge core_clk);
        chk("group_addr", 64'hAA, {56'h0, group_addr});
        chk("chain_flags", 64'h0, {62'h0, chain_first, chain_last});
        chk("lamps", 64'h1F, {59'h0, cfg_busy, full_indicator,
            error_indicator, data_present_indicator, buffer_clear});
        sys_rst <= 1'b0;
        while (cfg_busy !== 1'b0 && cyc < 19000) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        chk("lamps_off", 64'h0, {61'h0, full_indicator, error_indicator,
            data_present_indicator});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        r = rnd();
        rotary_a32_hi = {r[7:1], 1'b1};
        rotary_a24_lo = r[15:8];
        rotary_a32_mid = ~r[15:8];
        rotary_a24_hi = r[23:16];
        g = {1'b1, r[30:25], 1'b0};
        @(posedge core_clk);
        chk("core_a", {35'h0, 1'b0, 12'h014, 16'hFFD8}, {35'h0, core_match_en,
            core_match_width, core_match_offset});
        chk("core_b", {27'h0, 12'h008, 12'h004, 9'h100, 4'h0}, {27'h0,
            core_extra_search, core_reject_margin, core_fifo_size,
            core_hit_limit});
        chk("core_c", {59'h0, vsd_pkg::DEAD_TIME_CODE, vsd_pkg::EDGE_LEADING,
            1'b1}, {59'h0, core_dead_time, core_edge_mode,
            core_channels_on});
        reset_state();
        for (int i = 0; i < 64; i++) begin
            r = rnd();
            a = (i < 32) ? {rotary_a32_hi, rotary_a32_mid, 16'h1000} :
                {8'h00, rotary_a24_lo, 16'h1000};
            acc(a, i[5:0], 1'b1, r[15:0], am_ok(i[5:0]));
            if (am_ok(i[5:0]))
                chk("slot", {59'h0, r[4:0]}, {59'h0, slot_number_tag});
        end
        acc({rotary_a32_hi ^ 8'h02, rotary_a32_mid, 16'h1000}, 6'h09, 1'b1,
            16'h0005, 1'b0);
        acc({8'h00, rotary_a24_lo ^ 8'h01, 16'h1000}, 6'h39, 1'b1, 16'h0005,
            1'b0);
        $display("test base decode done");
        a = {rotary_a32_hi, rotary_a32_mid, 16'h1010};
        acc(a, 6'h0D, 1'b1, {8'h00, g}, 1'b1);
        chk("group_addr", {56'h0, g}, {56'h0, group_addr});
        for (int i = 3; i >= 0; i--) begin
            acc(a + 32'h2, 6'h09, 1'b1, 16'(i), 1'b1);
            chk("chain_flags", 64'(i), {62'h0, chain_first, chain_last});
        end
        acc(a + 32'h2, 6'h09, 1'b1, 16'h0002, 1'b1);
        r = rnd();
        s = r[4:0];
        acc({g, 8'h00, 16'h1000}, 6'h09, 1'b1, {11'h0, s}, 1'b1);
        chk("slot", {59'h0, s}, {59'h0, slot_number_tag});
        acc({g, 8'h01, 16'h1000}, 6'h09, 1'b1, 16'h0003, 1'b0);
        acc({g, 8'h00, 16'h1000}, 6'h39, 1'b1, 16'h0003, 1'b0);
        acc({g ^ 8'h04, 8'h00, 16'h1000}, 6'h09, 1'b1, 16'h3, 1'b0);
        chk("slot", {59'h0, s}, {59'h0, slot_number_tag});
        $display("test multicast done");
        @(posedge core_clk);
        buffer_word <= r;
        buffer_word_is_tag <= 1'b1;
        buffer_valid <= 1'b1;
        acc({g, 8'h00, 16'h1000}, 6'h0B, 1'b0, 16'h0, 1'b0);
        acc({g, 8'h00, 16'h0000}, 6'h09, 1'b0, 16'h0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            acc({g, 8'h00, 16'h0000}, k ? vsd_pkg::AM_A32_BLT :
                vsd_pkg::AM_A32_MBLT, 1'b0, 16'h0, 1'b1);
            chk("tag_word", {32'h0, s, r[26:0]}, {32'h0, rd_s});
        end
        tok_base = tok_cnt;
        buffer_done <= 1'b1;
        acc({g, 8'h00, 16'h0000}, 6'h0B, 1'b0, 16'h0, 1'b1);
        chk("token_out", 64'h1, {63'h0, tok_cnt > tok_base});
        acc(a + 32'h2, 6'h09, 1'b1, 16'h0003, 1'b1);
        acc({g, 8'h00, 16'h0000}, 6'h0B, 1'b0, 16'h0, 1'b0);
        chain_in <= 1'b1;
        tok_base = tok_cnt;
        acc({g, 8'h00, 16'h0000}, 6'h0F, 1'b0, 16'h0, 1'b1);
        chk("token_mid", 64'h1, {63'h0, tok_cnt > tok_base});
        acc(a + 32'h2, 6'h09, 1'b1, 16'h0001, 1'b1);
        tok_base = tok_cnt;
        acc({g, 8'h00, 16'h0000}, 6'h0C, 1'b0, 16'h0, 1'b1);
        chk("token_last", 64'h0, {63'h0, tok_cnt > tok_base});
        chain_in <= 1'b0;
        acc(a + 32'h2, 6'h09, 1'b1, 16'h0000, 1'b1);
        acc({g, 8'h00, 16'h0000}, 6'h0B, 1'b0, 16'h0, 1'b0);
        $display("test chained read done");
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        reset_state();
        $display("test second reset done");
        close_out();
    end
endmodule
